// [perf_monitor_pkg.sv]
// Purpose: constants and types for the link counter snapshot bank
// Assumes: apb data 32 bits, one register per aligned word
// Notes: byte address of a register is four times its index
package perf_monitor_pkg;
    localparam int NUM_CNT = 9;
    // counter order: crc4, align bit, align pos, oof, prbs, lcv,
    // nt crc, far end block, nt far end block
    localparam int CNT_W [NUM_CNT] = '{10, 12, 3, 5, 16, 16, 10, 10, 10};
    localparam int CNT_CRC4 = 0;
    localparam int CNT_ALIGN_BIT = 1;
    localparam int CNT_ALIGN_POS = 2;
    localparam int CNT_OOF = 3;
    localparam int CNT_PRBS = 4;
    localparam int CNT_LCV = 5;
    localparam int CNT_NT_CRC = 6;
    localparam int CNT_FAR_END_BLOCK_ERR_COUNT = 7;
    localparam int CNT_NT_FAR_END_BLOCK_ERR_COUNT = 8;

    localparam logic [5:0] IDX_CRC4_LOW = 6'h00;
    localparam logic [5:0] IDX_CRC4_HIGH = 6'h01;
    localparam logic [5:0] IDX_ALIGN_BIT_LOW = 6'h02;
    localparam logic [5:0] IDX_ALIGN_BIT_HIGH = 6'h03;
    localparam logic [5:0] IDX_ALIGN_POS = 6'h04;
    localparam logic [5:0] IDX_OOF = 6'h05;
    localparam logic [5:0] IDX_PRBS_LOW = 6'h06;
    localparam logic [5:0] IDX_PRBS_HIGH = 6'h07;
    localparam logic [5:0] IDX_LCV_LOW = 6'h08;
    localparam logic [5:0] IDX_LCV_HIGH = 6'h09;
    localparam logic [5:0] IDX_NT_CRC_LOW = 6'h0a;
    localparam logic [5:0] IDX_NT_CRC_HIGH = 6'h0b;
    localparam logic [5:0] IDX_FAR_END_BLOCK_ERR_COUNT_LOW = 6'h0c;
    localparam logic [5:0] IDX_FAR_END_BLOCK_ERR_COUNT_HIGH = 6'h0d;
    localparam logic [5:0] IDX_NT_FAR_END_BLOCK_ERR_COUNT_LOW = 6'h0e;
    localparam logic [5:0] IDX_NT_FAR_END_BLOCK_ERR_COUNT_HIGH = 6'h0f;
    localparam logic [5:0] IDX_CTRL = 6'h10;

    // control register fields
    localparam int CTRL_AUTO_BIT = 0;
    localparam int CTRL_TRIG_BIT = 1;
    localparam int CTRL_HDB3_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [7:0] MAP_RESET = 8'h00;

    // one second auto snapshot period at 200 MHz
    localparam int SNAP_PERIOD_MS = 1000;
    localparam int CLK_FREQ_KHZ = 200000;
    localparam int SNAP_PERIOD_CYCLES = SNAP_PERIOD_MS * CLK_FREQ_KHZ;
    localparam int TICK_W = 28;

    typedef struct packed {
        logic crc4;
        logic align_bit;
        logic align_pos;
        logic out_of_frame_count;
        logic prbs;
        logic bpv;
        logic hdb3_cv;
        logic nt_crc;
        logic far_end_block_err_count;
        logic nt_far_end_block_err_count;
    } perf_monitor_evt_t;
endpackage : perf_monitor_pkg

// [perf_monitor_counters_top.sv]
// Purpose: counter snapshot bank for one link, read over apb
// Assumes: event inputs are one-cycle pulses on SYS_CLK_IN
// Notes:
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module perf_monitor_counters_top
    import perf_monitor_pkg::*;
#(
    parameter int SNAP_CYCLES = SNAP_PERIOD_CYCLES
)
(
    input wire logic SYS_CLK_IN,
    input wire logic RST_B_IN,
    input wire perf_monitor_evt_t EVENT_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [31:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [3:0] PSTRB_IN,
    output logic PREADY_OUT,
    output logic [31:0] PRDATA_OUT,
    output logic PSLVERR_OUT
);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SNAP_CYCLES - 1);

    logic [2:0] ctrl;
    logic [2:0] next_ctrl;
    logic pready;
    logic next_pready;
    logic [31:0] prdata;
    logic [31:0] next_prdata;
    logic pslverr;
    logic next_pslverr;
    logic [TICK_W-1:0] tick_cnt;
    logic [TICK_W-1:0] next_tick_cnt;
    logic tick;
    logic next_tick;
    logic [15:0] cnt [NUM_CNT];
    logic [15:0] map_q [NUM_CNT];
    logic [NUM_CNT-1:0] ev;
    logic snap;
    logic setup;
    logic access;
    logic [5:0] idx;
    logic mapped;
    logic ctrl_wr;
    logic trig_rise;

    assign setup = PSEL_IN && !PENABLE_IN;
    assign access = PSEL_IN && PENABLE_IN && pready;
    assign idx = PADDR_IN[7:2];
    assign mapped = (PADDR_IN[31:8] == 24'h000000)
        && (PADDR_IN[1:0] == 2'h0) && (idx <= IDX_CTRL);
    // only the low byte lane carries control bits
    assign ctrl_wr = access && PWRITE_IN && mapped && (idx == IDX_CTRL)
        && PSTRB_IN[0];
    assign trig_rise = ctrl_wr && PWDATA_IN[CTRL_TRIG_BIT]
        && !ctrl[CTRL_TRIG_BIT];
    // one shared strobe keeps every register on the same instant
    assign snap = trig_rise || (ctrl[CTRL_AUTO_BIT] && tick);

    always_comb
    begin
        ev = '0;
        ev[CNT_CRC4] = EVENT_IN.crc4;
        ev[CNT_ALIGN_BIT] = EVENT_IN.align_bit;
        ev[CNT_ALIGN_POS] = EVENT_IN.align_pos;
        ev[CNT_OOF] = EVENT_IN.out_of_frame_count;
        ev[CNT_PRBS] = EVENT_IN.prbs;
        // decode mode picks which violation kind is counted
        ev[CNT_LCV] = ctrl[CTRL_HDB3_BIT] ? EVENT_IN.hdb3_cv
            : EVENT_IN.bpv;
        ev[CNT_NT_CRC] = EVENT_IN.nt_crc;
        ev[CNT_FAR_END_BLOCK_ERR_COUNT] = EVENT_IN.far_end_block_err_count;
        ev[CNT_NT_FAR_END_BLOCK_ERR_COUNT] = EVENT_IN.nt_far_end_block_err_count;
    end

    // one second divider, free running so the phase never drifts
    always_comb
    begin
        next_tick = (tick_cnt == TICK_LAST);
        next_tick_cnt = next_tick ? '0 : tick_cnt + 1'b1;
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end
        else
        begin
            tick_cnt <= next_tick_cnt;
            tick <= next_tick;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CNT; gi++)
        begin : g_cnt
            localparam logic [15:0] CMAX = 16'((1 << CNT_W[gi]) - 1);
            logic [15:0] next_cnt;
            logic [15:0] next_map;
            always_comb
            begin
                next_cnt = cnt[gi];
                next_map = map_q[gi];
                if (snap)
                begin
                    // the event of the snapshot cycle opens the new period
                    next_map = cnt[gi];
                    next_cnt = {15'h0000, ev[gi]};
                end
                else if (ev[gi] && (cnt[gi] != CMAX))
                begin
                    // saturate rather than wrap so overflow stays visible
                    next_cnt = cnt[gi] + 16'h0001;
                end
            end
            always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
            begin
                if (!RST_B_IN)
                begin
                    cnt[gi] <= 16'h0000;
                    map_q[gi] <= 16'h0000;
                end
                else
                begin
                    cnt[gi] <= next_cnt;
                    map_q[gi] <= next_map;
                end
            end
        end
    endgenerate

    function automatic logic [7:0] rd_byte(input logic [5:0] a);
        logic [7:0] b;
        b = MAP_RESET;
        if (a == IDX_CRC4_LOW)
            b = map_q[CNT_CRC4][7:0];
        else if (a == IDX_CRC4_HIGH)
            b = {2'h0, map_q[CNT_CRC4][9:8], 4'h0};
        else if (a == IDX_ALIGN_BIT_LOW)
            b = map_q[CNT_ALIGN_BIT][7:0];
        else if (a == IDX_ALIGN_BIT_HIGH)
            b = {4'h0, map_q[CNT_ALIGN_BIT][11:8]};
        else if (a == IDX_ALIGN_POS)
            b = {5'h00, map_q[CNT_ALIGN_POS][2:0]};
        else if (a == IDX_OOF)
            b = {3'h0, map_q[CNT_OOF][4:0]};
        else if (a == IDX_PRBS_LOW)
            b = map_q[CNT_PRBS][7:0];
        else if (a == IDX_PRBS_HIGH)
            b = map_q[CNT_PRBS][15:8];
        else if (a == IDX_LCV_LOW)
            b = map_q[CNT_LCV][7:0];
        else if (a == IDX_LCV_HIGH)
            b = map_q[CNT_LCV][15:8];
        else if (a == IDX_NT_CRC_LOW)
            b = map_q[CNT_NT_CRC][7:0];
        else if (a == IDX_NT_CRC_HIGH)
            b = {2'h0, map_q[CNT_NT_CRC][9:8], 4'h0};
        else if (a == IDX_FAR_END_BLOCK_ERR_COUNT_LOW)
            b = map_q[CNT_FAR_END_BLOCK_ERR_COUNT][7:0];
        else if (a == IDX_FAR_END_BLOCK_ERR_COUNT_HIGH)
            b = {2'h0, map_q[CNT_FAR_END_BLOCK_ERR_COUNT][9:8], 4'h0};
        else if (a == IDX_NT_FAR_END_BLOCK_ERR_COUNT_LOW)
            b = map_q[CNT_NT_FAR_END_BLOCK_ERR_COUNT][7:0];
        else if (a == IDX_NT_FAR_END_BLOCK_ERR_COUNT_HIGH)
            b = {2'h0, map_q[CNT_NT_FAR_END_BLOCK_ERR_COUNT][9:8], 4'h0};
        else if (a == IDX_CTRL)
            b = {5'h00, ctrl};
        return b;
    endfunction : rd_byte

    // answer is prepared in setup, so every access has zero wait states
    always_comb
    begin
        next_pready = setup;
        next_prdata = 32'h00000000;
        next_pslverr = 1'b0;
        next_ctrl = ctrl;
        if (setup)
        begin
            next_pslverr = !mapped;
            if (!PWRITE_IN && mapped)
                next_prdata = {24'h000000, rd_byte(idx)};
        end
        if (ctrl_wr)
            next_ctrl = PWDATA_IN[2:0];
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            ctrl <= CTRL_RESET;
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            ctrl <= next_ctrl;
            pready <= next_pready;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    assign PREADY_OUT = pready;
    assign PRDATA_OUT = prdata;
    assign PSLVERR_OUT = pslverr;

    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!RST_B_IN);

    property p_group_snap;
        snap |=> (map_q[CNT_CRC4] == $past(cnt[CNT_CRC4]))
            && (map_q[CNT_NT_FAR_END_BLOCK_ERR_COUNT] == $past(cnt[CNT_NT_FAR_END_BLOCK_ERR_COUNT]));
    endproperty
    a_group_snap: assert property (p_group_snap)
        else $error("mapping group not loaded together");

    property p_trig_rise;
        (ctrl_wr && PWDATA_IN[CTRL_TRIG_BIT] && !ctrl[CTRL_TRIG_BIT])
            |=> map_q[CNT_PRBS] == $past(cnt[CNT_PRBS]);
    endproperty
    a_trig_rise: assert property (p_trig_rise)
        else $error("trigger rise did not snapshot");

    property p_auto_tick;
        (ctrl[CTRL_AUTO_BIT] && tick)
            |=> map_q[CNT_OOF] == $past(cnt[CNT_OOF]);
    endproperty
    a_auto_tick: assert property (p_auto_tick)
        else $error("auto snapshot missing");

    property p_no_spurious;
        $changed(map_q[CNT_LCV]) |-> $past(snap);
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("snapshot without cause");

    property p_crc_high_read;
        (setup && !PWRITE_IN && mapped && idx == IDX_CRC4_HIGH)
            |=> PRDATA_OUT == {26'h0, $past(map_q[CNT_CRC4][9:8]), 4'h0};
    endproperty
    a_crc_high_read: assert property (p_crc_high_read)
        else $error("crc4 high byte misplaced");

    property p_align_high_read;
        (setup && !PWRITE_IN && mapped && idx == IDX_ALIGN_BIT_HIGH)
            |=> PRDATA_OUT == {28'h0, $past(map_q[CNT_ALIGN_BIT][11:8])};
    endproperty
    a_align_high_read: assert property (p_align_high_read)
        else $error("alignment high byte misplaced");

    property p_prbs_high_read;
        (setup && !PWRITE_IN && mapped && idx == IDX_PRBS_HIGH)
            |=> PRDATA_OUT == {24'h0, $past(map_q[CNT_PRBS][15:8])};
    endproperty
    a_prbs_high_read: assert property (p_prbs_high_read)
        else $error("prbs high byte misplaced");

    property p_nt_crc_high_read;
        (setup && !PWRITE_IN && mapped && idx == IDX_NT_CRC_HIGH)
            |=> PRDATA_OUT == {26'h0, $past(map_q[CNT_NT_CRC][9:8]), 4'h0};
    endproperty
    a_nt_crc_high_read: assert property (p_nt_crc_high_read)
        else $error("nt crc high byte misplaced");

    property p_far_end_block_err_count_high_read;
        (setup && !PWRITE_IN && mapped && idx == IDX_FAR_END_BLOCK_ERR_COUNT_HIGH)
            |=> PRDATA_OUT == {26'h0, $past(map_q[CNT_FAR_END_BLOCK_ERR_COUNT][9:8]), 4'h0};
    endproperty
    a_far_end_block_err_count_high_read: assert property (p_far_end_block_err_count_high_read)
        else $error("far end block high byte misplaced");

    property p_nt_far_end_block_err_count_low_read;
        (setup && !PWRITE_IN && mapped && idx == IDX_NT_FAR_END_BLOCK_ERR_COUNT_LOW)
            |=> PRDATA_OUT == {24'h0, $past(map_q[CNT_NT_FAR_END_BLOCK_ERR_COUNT][7:0])};
    endproperty
    a_nt_far_end_block_err_count_low_read: assert property (p_nt_far_end_block_err_count_low_read)
        else $error("nt far end low byte misplaced");

    property p_nt_far_end_block_err_count_high_read;
        (setup && !PWRITE_IN && mapped && idx == IDX_NT_FAR_END_BLOCK_ERR_COUNT_HIGH)
            |=> PRDATA_OUT == {26'h0, $past(map_q[CNT_NT_FAR_END_BLOCK_ERR_COUNT][9:8]), 4'h0};
    endproperty
    a_nt_far_end_block_err_count_high_read: assert property (p_nt_far_end_block_err_count_high_read)
        else $error("nt far end high byte misplaced");

    property p_pos_width;
        cnt[CNT_ALIGN_POS] <= 16'h0007;
    endproperty
    a_pos_width: assert property (p_pos_width)
        else $error("position count exceeds three bits");

    property p_oof_width;
        cnt[CNT_OOF] <= 16'h001f;
    endproperty
    a_oof_width: assert property (p_oof_width)
        else $error("frame loss count exceeds five bits");

    property p_lcv_hdb3;
        (!snap && ctrl[CTRL_HDB3_BIT] && EVENT_IN.hdb3_cv
            && cnt[CNT_LCV] != 16'hffff)
            |=> cnt[CNT_LCV] == $past(cnt[CNT_LCV]) + 16'h0001;
    endproperty
    a_lcv_hdb3: assert property (p_lcv_hdb3)
        else $error("hdb3 violation not counted");

    property p_restart;
        snap |=> cnt[CNT_ALIGN_BIT] == {15'h0000, $past(ev[CNT_ALIGN_BIT])};
    endproperty
    a_restart: assert property (p_restart)
        else $error("counter not restarted on snapshot");

    property p_hold;
        !snap |=> $stable(map_q[CNT_PRBS]) && $stable(map_q[CNT_FAR_END_BLOCK_ERR_COUNT]);
    endproperty
    a_hold: assert property (p_hold)
        else $error("mapping changed between snapshots");

    c_manual: cover property (trig_rise && PREADY_OUT);
    c_auto: cover property (ctrl[CTRL_AUTO_BIT] && tick);
    c_event_at_snap: cover property (snap && ev[CNT_CRC4]);
    c_err: cover property (PSLVERR_OUT && PREADY_OUT);
endmodule : perf_monitor_counters_top
`default_nettype wire

// [tb_top.sv]
// Purpose: self-checking bench for the link counter snapshot bank
// Assumes: zero wait apb slave, snapshot period cut to 50 cycles
// Notes: each access starts on a fresh edge, so no signal is driven twice
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import perf_monitor_pkg::*;
    localparam int SNAP = 50;
    typedef int perf_monitor_cnt_t [10];
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, r;
    logic [3:0] pstrb;
    logic e;
    perf_monitor_evt_t ev;
    int bad_count, checks_done, n;
    // order: crc4 align pos oof prbs bpv hdb3 ntcrc far_end_block_err_count ntfebe
    perf_monitor_cnt_t ca = '{300, 260, 9, 40, 290, 270, 5, 280, 257, 299};
    perf_monitor_cnt_t cb = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10};
    perf_monitor_cnt_t zero = '{default: 0};
    perf_monitor_cnt_t ones = '{default: 1};

    perf_monitor_counters_top #(.SNAP_CYCLES(SNAP)) DUT (
        .SYS_CLK_IN(clk),
        .RST_B_IN(rst_b),
        .EVENT_IN(ev),
        .PSEL_IN(psel),
        .PENABLE_IN(penable),
        .PWRITE_IN(pwrite),
        .PADDR_IN(paddr),
        .PWDATA_IN(pwdata),
        .PSTRB_IN(pstrb),
        .PREADY_OUT(pready),
        .PRDATA_OUT(prdata),
        .PSLVERR_OUT(pslverr)
    );

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    task automatic chk_val(string nm, logic [31:0] x, logic [31:0] g);
        checks_done++;
        if (g !== x)
        begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", nm, x, g);
        end
    endtask : chk_val

    task automatic chk_bit(string nm, logic x, logic g);
        checks_done++;
        if (g !== x)
        begin
            bad_count++;
            $display("[ERR] %s exp %b got %b", nm, x, g);
        end
    endtask : chk_bit

    task automatic xfer(input logic w, input logic [31:0] a, d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // request stands until pready is seen high at a rising edge
        do
        begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        chk_val("access cycles", 32'h1, 32'(k));
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(logic [31:0] a, logic [31:0] d);
        xfer(1'b1, a, d);
        chk_bit("wr pslverr", 1'b0, e);
    endtask : wr

    task automatic rd(logic [31:0] a, logic [31:0] x, logic xe);
        xfer(1'b0, a, 32'h0);
        chk_val($sformatf("rd %h", a), x, r);
        chk_bit("rd pslverr", xe, e);
    endtask : rd

    function automatic logic [31:0] exp_reg(int i, perf_monitor_cnt_t c, bit h);
        int w[9] = '{10, 12, 3, 5, 16, 16, 10, 10, 10};
        int k[16] = '{0, 0, 1, 1, 2, 3, 4, 4, 5, 5, 6, 6, 7, 7, 8, 8};
        int s;
        int mx;
        logic [15:0] v;
        s = k[i] + ((k[i] >= 6 || (k[i] == 5 && h)) ? 1 : 0);
        mx = (1 << w[k[i]]) - 1;
        // counters saturate rather than wrap
        v = 16'(c[s] > mx ? mx : c[s]);
        case (i)
            1, 11, 13, 15: return {26'h0, v[9:8], 4'h0};
            3: return {28'h0, v[11:8]};
            7, 9: return {24'h0, v[15:8]};
            default: return {24'h0, v[7:0]};
        endcase
    endfunction : exp_reg

    task automatic chk_all(perf_monitor_cnt_t c, bit h);
        for (int i = 0; i < 16; i++)
            rd(32'(i * 4), exp_reg(i, c, h), 1'b0);
    endtask : chk_all

    task automatic pulse(perf_monitor_cnt_t c);
        int m;
        perf_monitor_evt_t v;
        m = 0;
        foreach (c[j])
            m = (c[j] > m) ? c[j] : m;
        for (int i = 0; i < m; i++)
        begin
            for (int j = 0; j < 10; j++)
                v[9 - j] = (i < c[j]);
            @(posedge clk);
            ev <= v;
        end
        @(posedge clk);
        ev <= '0;
    endtask : pulse

    initial
    begin
        repeat (10000) @(posedge clk);
        bad_count++;
        wrap_up();
    end

    initial
    begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        ev = '0;
        bad_count = 0;
        checks_done = 0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        chk_all(zero, 1'b0);
        rd(32'h40, 32'h0, 1'b0);
        rd(32'h44, 32'h0, 1'b1);
        rd(32'h100, 32'h0, 1'b1);
        rd(32'h2, 32'h0, 1'b1);
        $display("test reset done");
        pulse(ca);
        chk_all(zero, 1'b0);
        wr(32'h40, 32'h2);
        chk_all(ca, 1'b0);
        rd(32'h40, 32'h2, 1'b0);
        wr(32'h0, 32'hff);
        rd(32'h0, exp_reg(0, ca, 1'b0), 1'b0);
        $display("test manual snapshot done");
        pulse(cb);
        wr(32'h40, 32'h2);
        chk_all(ca, 1'b0);
        wr(32'h40, 32'h0);
        // a control write without its byte lane must not fire the trigger
        pstrb <= 4'he;
        wr(32'h40, 32'h2);
        pstrb <= 4'hf;
        rd(32'h40, 32'h0, 1'b0);
        wr(32'h40, 32'h2);
        chk_all(cb, 1'b0);
        wr(32'h40, 32'h4);
        pulse(cb);
        wr(32'h40, 32'h6);
        chk_all(cb, 1'b1);
        $display("test restart and decode mode done");
        wr(32'h40, 32'h1);
        repeat (SNAP + 5) @(posedge clk);
        chk_all(zero, 1'b0);
        pulse(ones);
        n = 0;
        // a single-cycle burst cannot be split by a period tick
        do
        begin
            xfer(1'b0, 32'h0, 32'h0);
            n++;
        end while (r !== 32'h1 && n < 40);
        // stop the period so the group check cannot straddle a refresh
        wr(32'h40, 32'h0);
        chk_all(ones, 1'b0);
        $display("test auto snapshot done");
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
